/* design/dcwd_pkg.sv */
// Constants, register map and field layout of the drive control word decoder.
// Notes on behaviour
// - Process block: control word then reference in; status then frequency out.
// - Control word uses the native layout only while the profile setting equals 1.
// - Bits 1:0 pick preset reference 1 to 4.
// - Bit 2 low requests DC braking and stop.
// - Bit 3 low coasts the motor at once; high permits starting.
// - Bit 4 low requests a quick stop on the quick-stop ramp.
// - Bit 5 low freezes output frequency; only speed up/down inputs move it.
// - While frozen, bit 6 and start input cannot stop; coast or brake can.
// - Bit 6 low ramps to stop; high allows starting.
// - Trip reset fires only on a rising edge of bit 7.
// - Bit 8 high selects jog frequency.
// - Bit 9 selects ramp pair one or two.
// - Control word acted on only when bit 10 is high.
// - Per-function gating mode combines serial bit with digital input.
// - Parameter values travel as whole numbers scaled by their factor.
// - Read answer echoes number and index with the current value.
// - Answers 0001 word, 0010 double, 0111 with fault number; text requests get 0111.
// - Lower eleven key bits carry the parameter number, echoed back.
package dcwd_pkg;
	localparam logic [7:0]  ADDR_PROFILE    = 8'h00;
	localparam logic [7:0]  ADDR_GATE       = 8'h04;
	localparam logic [7:0]  ADDR_STATE      = 8'h08;
	localparam logic [7:0]  ADDR_PARAM_SEL  = 8'h0C;
	localparam logic [7:0]  ADDR_PARAM_DATA = 8'h10;
	localparam logic [1:0]  PROFILE_NATIVE  = 2'h1;
	localparam logic [1:0]  PROFILE_RESET   = 2'h1;
	localparam logic [7:0]  GATE_RESET      = 8'h55;
	localparam logic [1:0]  GATE_DIGITAL    = 2'h0;
	localparam logic [1:0]  GATE_SERIAL     = 2'h1;
	localparam logic [1:0]  GATE_AND        = 2'h2;
	localparam logic [1:0]  GATE_OR         = 2'h3;
	localparam int          GATE_PRESET_POS = 0;
	localparam int          GATE_BRAKE_POS  = 2;
	localparam int          GATE_COAST_POS  = 4;
	localparam int          GATE_START_POS  = 6;
	localparam int          CW_PRESET_LO    = 0;
	localparam int          CW_PRESET_HI    = 1;
	localparam int          CW_DC_BRAKE_N   = 2;
	localparam int          CW_COAST_N      = 3;
	localparam int          CW_QSTOP_N      = 4;
	localparam int          CW_FREEZE_N     = 5;
	localparam int          CW_START        = 6;
	localparam int          CW_RESET        = 7;
	localparam int          CW_JOG          = 8;
	localparam int          CW_RAMP2        = 9;
	localparam int          CW_DATA_VALID   = 10;
	localparam int          KEY_CODE_LSB    = 12;
	localparam int          PNUM_W          = 11;
	localparam logic [3:0]  REQ_NONE        = 4'h0;
	localparam logic [3:0]  REQ_READ        = 4'h1;
	localparam logic [3:0]  REQ_WR_WORD     = 4'h2;
	localparam logic [3:0]  REQ_WR_DWORD    = 4'h3;
	localparam logic [3:0]  REQ_EE_DWORD    = 4'hD;
	localparam logic [3:0]  REQ_EE_WORD     = 4'hE;
	localparam logic [3:0]  REQ_TEXT        = 4'hF;
	localparam logic [3:0]  RSP_NONE        = 4'h0;
	localparam logic [3:0]  RSP_WORD        = 4'h1;
	localparam logic [3:0]  RSP_DWORD       = 4'h2;
	localparam logic [3:0]  RSP_FAULT       = 4'h7;
	localparam logic [15:0] FAULT_NO_PARAM  = 16'h0000;
	localparam logic [15:0] FAULT_NO_INDEX  = 16'h0003;
	localparam logic [15:0] FAULT_TYPE      = 16'h0005;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam int          DIN_W           = 8;
endpackage : dcwd_pkg

/* design/dcwd_decoder.sv */
// Control word interpreter, parameter table and AXI4-Lite register slave.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module dcwd_decoder import dcwd_pkg::*; #(
	parameter int PARAM_DEPTH = 16
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        tel_valid,
	input  wire logic [15:0] parameter_key_word,
	input  wire logic [15:0] parameter_subindex_word,
	input  wire logic [31:0] parameter_value_words,
	input  wire logic [15:0] first_process_word,
	input  wire logic [15:0] second_process_word,
	input  wire logic [15:0] drive_status_word,
	input  wire logic [15:0] drive_output_freq,
	output logic             rsp_valid,
	output logic [15:0]      rsp_key_word,
	output logic [15:0]      rsp_subindex_word,
	output logic [31:0]      rsp_value_words,
	output logic [15:0]      rsp_first_process_word,
	output logic [15:0]      rsp_second_process_word,
	output logic [15:0]      reference_value,
	input  wire logic [7:0]  din_pins,
	output logic [1:0]       preset_sel,
	output logic             dc_brake,
	output logic             coast,
	output logic             quick_stop,
	output logic             freq_freeze,
	output logic             run_enable,
	output logic             trip_reset,
	output logic             jog,
	output logic             ramp2_sel,
	output logic             freq_up,
	output logic             freq_down
);
	if (PARAM_DEPTH < 2 || PARAM_DEPTH > 2048) begin : g_depth_check
		$error("PARAM_DEPTH must lie in 2..2048");
	end

	localparam int AW = $clog2(PARAM_DEPTH);

	logic [15:0]      param_mem [PARAM_DEPTH];
	logic [DIN_W-1:0] din_s1_q, din_s2_q;
	logic [1:0]       profile_q;
	logic [7:0]       gate_q;
	logic [AW-1:0]    psel_q;
	logic [15:0]      cw_q, cw_prev_q;
	logic             cw_new_q;
	logic [7:0]       aw_addr_q;
	logic [31:0]      w_data_q;
	logic [3:0]       w_strb_q;
	logic             aw_full_q, w_full_q;

	// Digital inputs: preset lsb/msb, brake_n, coast_n, start, speed up, speed down, spare.
	always_ff @(posedge aclk) begin
		din_s1_q <= din_pins;
		din_s2_q <= din_s1_q;
	end

	// A control word is taken only in the native layout and with its valid bit set.
	wire cw_accept = tel_valid && profile_q == PROFILE_NATIVE
		&& first_process_word[CW_DATA_VALID];

	// Latch the whole control word at once so no half-updated word is ever decoded.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cw_q      <= 16'h0000;
			cw_prev_q <= 16'h0000;
			cw_new_q  <= 1'b0;
			reference_value <= 16'h0000;
		end else begin
			cw_new_q <= cw_accept;
			if (cw_accept) begin
				cw_prev_q       <= cw_q;
				cw_q            <= first_process_word;
				reference_value <= second_process_word;
			end
		end
	end

	function automatic logic gate_fn(input logic [1:0] mode, input logic ser, input logic dig);
		unique case (mode)
			GATE_DIGITAL: gate_fn = dig;
			GATE_SERIAL:  gate_fn = ser;
			GATE_AND:     gate_fn = ser & dig;
			GATE_OR:      gate_fn = ser | dig;
		endcase
	endfunction : gate_fn

	wire [1:0] gm_preset = gate_q[GATE_PRESET_POS +: 2];
	wire [1:0] gm_brake  = gate_q[GATE_BRAKE_POS +: 2];
	wire [1:0] gm_coast  = gate_q[GATE_COAST_POS +: 2];
	wire [1:0] gm_start  = gate_q[GATE_START_POS +: 2];
	wire [1:0] preset_d  = {gate_fn(gm_preset, cw_q[CW_PRESET_HI], din_s2_q[1]),
		gate_fn(gm_preset, cw_q[CW_PRESET_LO], din_s2_q[0])};
	wire brake_d  = !gate_fn(gm_brake, cw_q[CW_DC_BRAKE_N], din_s2_q[2]);
	wire coast_d  = !gate_fn(gm_coast, cw_q[CW_COAST_N], din_s2_q[3]);
	wire start_d  = gate_fn(gm_start, cw_q[CW_START], din_s2_q[4]);
	wire freeze_d = !cw_q[CW_FREEZE_N];
	// While frozen, start/stop requests are ignored; coasting and braking still stop.
	wire run_d    = (coast_d || brake_d) ? 1'b0 : (freeze_d ? run_enable : start_d);
	wire reset_d  = cw_new_q && cw_q[CW_RESET] && !cw_prev_q[CW_RESET];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			preset_sel  <= 2'h0;
			dc_brake    <= 1'b0;
			coast       <= 1'b1;
			quick_stop  <= 1'b0;
			freq_freeze <= 1'b0;
			run_enable  <= 1'b0;
			trip_reset  <= 1'b0;
			jog         <= 1'b0;
			ramp2_sel   <= 1'b0;
			freq_up     <= 1'b0;
			freq_down   <= 1'b0;
		end else begin
			preset_sel  <= preset_d;
			dc_brake    <= brake_d;
			coast       <= coast_d;
			quick_stop  <= !cw_q[CW_QSTOP_N];
			freq_freeze <= freeze_d;
			run_enable  <= run_d;
			trip_reset  <= reset_d;
			jog         <= cw_q[CW_JOG];
			ramp2_sel   <= cw_q[CW_RAMP2];
			freq_up     <= freeze_d && din_s2_q[5];
			freq_down   <= freeze_d && din_s2_q[6];
		end
	end

	// Parameter access: values are stored and returned as scaled whole numbers.
	wire [3:0]        req_code = parameter_key_word[15:KEY_CODE_LSB];
	wire [PNUM_W-1:0] req_pnum = parameter_key_word[PNUM_W-1:0];
	wire              pnum_ok  = {1'b0, req_pnum} < 12'(PARAM_DEPTH);
	wire [AW-1:0]     pidx     = req_pnum[AW-1:0];
	wire              idx_ok   = parameter_subindex_word[7:0] == 8'h00;
	wire is_wr_word = req_code == REQ_WR_WORD || req_code == REQ_EE_WORD;
	wire is_wr_dw   = req_code == REQ_WR_DWORD || req_code == REQ_EE_DWORD;
	wire is_known   = req_code == REQ_READ || is_wr_word || is_wr_dw;
	wire req_ok     = is_known && pnum_ok && idx_ok;
	wire tel_write  = tel_valid && req_ok && (is_wr_word || is_wr_dw);
	wire [15:0] new_val = tel_write ? parameter_value_words[15:0] : param_mem[pidx];

	wire [3:0] rsp_code = (req_code == REQ_NONE) ? RSP_NONE :
		!req_ok ? RSP_FAULT : is_wr_dw ? RSP_DWORD : RSP_WORD;
	wire [15:0] fault_no = (req_code == REQ_TEXT || !is_known) ? FAULT_TYPE :
		!pnum_ok ? FAULT_NO_PARAM : FAULT_NO_INDEX;
	wire [31:0] rsp_val = (req_code == REQ_NONE) ? 32'h0000_0000 :
		!req_ok ? {16'h0000, fault_no} : {16'h0000, new_val};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_valid               <= 1'b0;
			rsp_key_word            <= 16'h0000;
			rsp_subindex_word       <= 16'h0000;
			rsp_value_words         <= 32'h0000_0000;
			rsp_first_process_word  <= 16'h0000;
			rsp_second_process_word <= 16'h0000;
		end else begin
			rsp_valid <= tel_valid;
			if (tel_valid) begin
				rsp_key_word            <= {rsp_code, 1'b0, req_pnum};
				rsp_subindex_word       <= parameter_subindex_word;
				rsp_value_words         <= rsp_val;
				rsp_first_process_word  <= drive_status_word;
				rsp_second_process_word <= drive_output_freq;
			end
		end
	end

	// AXI4-Lite slave; address and data are taken independently, response follows both.
	wire aw_take  = s_axi_awvalid && s_axi_awready;
	wire w_take   = s_axi_wvalid && s_axi_wready;
	wire wr_go    = aw_full_q && w_full_q && !s_axi_bvalid;
	wire wr_map   = aw_addr_q == ADDR_PROFILE || aw_addr_q == ADDR_GATE
		|| aw_addr_q == ADDR_PARAM_SEL || aw_addr_q == ADDR_PARAM_DATA;
	wire ar_take  = s_axi_arvalid && s_axi_arready;
	// Strobes are kept with the data, since the master may drop them once W is taken.
	wire sw_param = wr_go && aw_addr_q == ADDR_PARAM_DATA && w_strb_q[0] && w_strb_q[1];
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (tel_write)
			param_mem[pidx] <= parameter_value_words[15:0];
		else if (sw_param)
			param_mem[psel_q] <= w_data_q[15:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			profile_q    <= PROFILE_RESET;
			gate_q       <= GATE_RESET;
			psel_q       <= '0;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
				if (aw_addr_q == ADDR_PROFILE && w_strb_q[0])
					profile_q <= w_data_q[1:0];
				if (aw_addr_q == ADDR_GATE && w_strb_q[0])
					gate_q <= w_data_q[7:0];
				if (aw_addr_q == ADDR_PARAM_SEL && w_strb_q[0])
					psel_q <= w_data_q[AW-1:0];
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	wire [31:0] state_word = {16'h0000, 5'h00, ramp2_sel, jog, trip_reset, run_enable,
		freq_freeze, quick_stop, coast, dc_brake, preset_sel, 1'b0};
	wire rd_map = s_axi_araddr == ADDR_PROFILE || s_axi_araddr == ADDR_GATE
		|| s_axi_araddr == ADDR_STATE || s_axi_araddr == ADDR_PARAM_SEL
		|| s_axi_araddr == ADDR_PARAM_DATA;
	wire [31:0] rd_val =
		s_axi_araddr == ADDR_PROFILE    ? {30'h0000_0000, profile_q} :
		s_axi_araddr == ADDR_GATE       ? {24'h00_0000, gate_q} :
		s_axi_araddr == ADDR_STATE      ? state_word :
		s_axi_araddr == ADDR_PARAM_SEL  ? 32'(psel_q) :
		s_axi_araddr == ADDR_PARAM_DATA ? {16'h0000, param_mem[psel_q]} : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	sequence s_cw_taken;
		cw_accept;
	endsequence
	sequence s_edge_bit7;
		cw_accept && first_process_word[CW_RESET] && !cw_q[CW_RESET];
	endsequence

	a_reset_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		s_edge_bit7 |-> ##2 trip_reset) else $error("trip reset missed on bit 7 edge");
	a_reset_level: assert property (@(posedge aclk) disable iff (!aresetn)
		trip_reset |=> !trip_reset) else $error("trip reset longer than one cycle");
	a_invalid_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		tel_valid && !first_process_word[CW_DATA_VALID] |=> $stable(cw_q))
		else $error("control word taken without valid bit");
	a_profile_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		tel_valid && profile_q != PROFILE_NATIVE |=> $stable(cw_q))
		else $error("control word taken in other profile");
	a_coast_serial: assert property (@(posedge aclk) disable iff (!aresetn)
		s_cw_taken ##0 (gm_coast == GATE_SERIAL && !first_process_word[CW_COAST_N])
		|-> ##2 coast && !run_enable) else $error("coast not applied");
	a_jog_ramp: assert property (@(posedge aclk) disable iff (!aresetn)
		s_cw_taken |-> ##2 jog == $past(first_process_word[CW_JOG], 2)
		&& ramp2_sel == $past(first_process_word[CW_RAMP2], 2))
		else $error("jog or ramp select wrong");
	a_freeze_run: assert property (@(posedge aclk) disable iff (!aresetn)
		freeze_d && !coast_d && !brake_d |=> run_enable == $past(run_enable))
		else $error("run state changed while frozen");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		tel_valid && req_code == REQ_READ && req_ok |=> rsp_valid
		&& rsp_key_word[15:12] == RSP_WORD
		&& rsp_key_word[10:0] == $past(req_pnum)) else $error("read answer wrong");
	a_fault_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		tel_valid && req_code == REQ_READ && !pnum_ok |=> rsp_key_word[15:12] == RSP_FAULT
		&& rsp_value_words == 32'h0000_0000) else $error("missing-parameter fault wrong");
endmodule : dcwd_decoder

/* dv/dcwd_tel_master.sv */
// Telegram source that stands in for the serial bus master.
`timescale 1ns/1ps
module dcwd_tel_master (
	input  wire logic        aclk,
	output logic             tel_valid,
	output logic [15:0]      key,
	output logic [15:0]      sub,
	output logic [31:0]      value,
	output logic [15:0]      ctl,
	output logic [15:0]      ref_val
);
	initial begin
		tel_valid = 1'b0;
		key = 16'h0000;
		sub = 16'h0000;
		value = 32'h00000000;
		ctl = 16'h0000;
		ref_val = 16'h0000;
	end

	// Released buses show inverted data so a stale sample never looks valid.
	task automatic send(input logic [3:0] c, input logic [10:0] n, input logic [15:0] s,
		input logic [15:0] v, input logic [15:0] cw, input logic [15:0] r);
		tel_valid <= 1'b1;
		key <= {c, 1'b0, n};
		sub <= s;
		value <= {16'h0000, v};
		ctl <= cw;
		ref_val <= r;
		@(posedge aclk);
		tel_valid <= 1'b0;
		key <= ~key;
		sub <= ~sub;
		value <= ~value;
		ctl <= ~ctl;
		ref_val <= ~ref_val;
	endtask : send
endmodule : dcwd_tel_master

/* dv/dcwd_decoder_tb_top.sv */
// Self-checking bench for the drive control word decoder.
`timescale 1ns/1ps
module dcwd_decoder_tb_top import dcwd_pkg::*;;
	localparam int DEPTH = 16;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, din_pins;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, preset_sel;
	logic [31:0] s_axi_rdata, rsp_value_words, val;
	logic [15:0] drive_status_word = 16'h0, drive_output_freq = 16'h0, key, sub, ctl, ref_val;
	logic [15:0] rsp_key_word, rsp_subindex_word, rsp_first_process_word;
	logic [15:0] rsp_second_process_word, reference_value, cw, prev, pv, ref_exp;
	logic        tel_valid, rsp_valid, dc_brake, coast, quick_stop, freq_freeze, run_enable;
	logic        trip_reset, jog, ramp2_sel, freq_up, freq_down, run_exp, run_ok;
	logic [3:0]  codes [6] = '{REQ_WR_WORD, REQ_WR_DWORD, REQ_EE_WORD, REQ_EE_DWORD,
		REQ_TEXT, REQ_NONE};
	logic [1:0]  gexp [4] = '{2'b10, 2'b01, 2'b00, 2'b11};
	int          seed = 32'h8281;
	int          bad_count = 0;
	int          checks_done = 0;
	wire logic [7:0] ctl_now = {preset_sel, dc_brake, coast, quick_stop, freq_freeze, jog,
		ramp2_sel};

	always #5 aclk = ~aclk;

	dcwd_tel_master i_master (.aclk(aclk), .tel_valid(tel_valid), .key(key), .sub(sub),
		.value(val), .ctl(ctl), .ref_val(ref_val));

	dcwd_decoder #(.PARAM_DEPTH(DEPTH)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tel_valid,
		.parameter_key_word(key), .parameter_subindex_word(sub), .parameter_value_words(val),
		.first_process_word(ctl), .second_process_word(ref_val), .drive_status_word,
		.drive_output_freq, .rsp_valid, .rsp_key_word, .rsp_subindex_word, .rsp_value_words,
		.rsp_first_process_word, .rsp_second_process_word, .reference_value, .din_pins,
		.preset_sel, .dc_brake, .coast, .quick_stop, .freq_freeze, .run_enable, .trip_reset,
		.jog, .ramp2_sel, .freq_up, .freq_down);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] exp_ctl(input logic [15:0] c);
		return {c[1:0], ~c[2], ~c[3], ~c[4], ~c[5], c[8], c[9]};
	endfunction : exp_ctl

	function automatic logic [3:0] exp_code(input logic [3:0] c);
		case (c)
			REQ_WR_WORD, REQ_EE_WORD: return RSP_WORD;
			REQ_WR_DWORD, REQ_EE_DWORD: return RSP_DWORD;
			REQ_NONE: return RSP_NONE;
			default: return RSP_FAULT;
		endcase
	endfunction : exp_code

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				chk(32'(s_axi_bresp), 32'(er));
				break;
			end
		end
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				chk(s_axi_rdata, ed);
				chk(32'(s_axi_rresp), 32'(er));
				break;
			end
		end
		@(posedge aclk);
	endtask : axi_rd

	// Sends one telegram and returns at the edge where decoded outputs are visible.
	task automatic tel(input logic [3:0] c, input logic [10:0] n, input logic [15:0] s,
		input logic [15:0] v, input logic [15:0] w);
		logic [15:0] st;
		logic [15:0] fq;
		st = 16'($random(seed));
		fq = 16'($random(seed));
		ref_exp = 16'($random(seed));
		drive_status_word <= st;
		drive_output_freq <= fq;
		i_master.send(c, n, s, v, w, ref_exp);
		@(posedge aclk);
		chk(32'(rsp_valid), 32'h1);
		@(posedge aclk);
		chk({rsp_first_process_word, rsp_second_process_word}, {st, fq});
	endtask : tel

	task automatic wrap_up;
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		$display("ERROR t=%0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		din_pins = 8'($random(seed));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'({coast, run_enable, preset_sel}), 32'h8);
		axi_rd(ADDR_PROFILE, 32'(PROFILE_RESET), RESP_OKAY);
		axi_rd(ADDR_GATE, 32'(GATE_RESET), RESP_OKAY);
		axi_rd(8'h40, 32'h0, RESP_SLVERR);
		axi_wr(8'h44, 32'h1, RESP_SLVERR);
		$display("test registers done");
		prev = 16'h0000;
		run_exp = 1'b0;
		run_ok = 1'b1;
		for (int i = 0; i < 40; i++) begin
			cw = 16'($random(seed)) | 16'h0400;
			tel(REQ_NONE, 11'h000, 16'h0000, 16'h0000, cw);
			chk(32'(ctl_now), 32'(exp_ctl(cw)));
			chk(32'(trip_reset), 32'(cw[7] & ~prev[7]));
			chk(32'(reference_value), 32'(ref_exp));
			if (cw[2] && cw[3] && cw[4]) begin
				if (cw[5]) run_ok = 1'b1;
				if (cw[5]) run_exp = cw[6];
				if (run_ok) chk(32'(run_enable), 32'(run_exp));
			end else begin
				run_ok = 1'b0;
			end
			prev = cw;
		end
		for (int j = 0; j < 3; j++) begin
			tel(REQ_NONE, 11'h000, 16'h0000, 16'h0000, (j > 0) ? 16'h04FC : 16'h047C);
			chk(32'({trip_reset, run_enable}), 32'({j == 1, 1'b1}));
			@(posedge aclk);
			chk(32'(trip_reset), 32'h0);
		end
		$display("test control word done");
		for (int j = 0; j < 6; j++) begin
			pv = 16'($random(seed));
			tel(codes[j], 11'(j + 1), 16'h0000, pv, 16'h0000);
			chk(32'(rsp_key_word), 32'({exp_code(codes[j]), 1'b0, 11'(j + 1)}));
			if (codes[j] == REQ_TEXT) chk(rsp_value_words, 32'(FAULT_TYPE));
			if (codes[j] == REQ_NONE) chk(rsp_value_words, 32'h0);
			if (exp_code(codes[j]) inside {RSP_WORD, RSP_DWORD}) begin
				tel(REQ_READ, 11'(j + 1), 16'h0000, 16'h0000, 16'h0000);
				chk(rsp_value_words, {16'h0000, pv});
				chk({rsp_key_word, rsp_subindex_word}, {RSP_WORD, 1'b0, 11'(j + 1), 16'h0});
			end
		end
		tel(REQ_READ, 11'(DEPTH), 16'h0000, 16'h0000, 16'h0000);
		chk({rsp_key_word[15:12], rsp_value_words[15:0]}, {RSP_FAULT, FAULT_NO_PARAM});
		tel(REQ_READ, 11'h001, 16'h0001, 16'h0000, 16'h0000);
		chk({rsp_key_word[15:12], rsp_value_words[15:0]}, {RSP_FAULT, FAULT_NO_INDEX});
		axi_wr(ADDR_PARAM_SEL, 32'h3, RESP_OKAY);
		axi_wr(ADDR_PARAM_DATA, 32'h1234, RESP_OKAY);
		axi_rd(ADDR_PARAM_DATA, 32'h1234, RESP_OKAY);
		tel(REQ_READ, 11'h003, 16'h0000, 16'h0000, 16'h0000);
		chk(rsp_value_words, 32'h1234);
		$display("test parameters done");
		tel(REQ_NONE, 11'h000, 16'h0000, 16'h0000, 16'h0303);
		chk(32'(ctl_now), 32'(exp_ctl(16'h04FC)));
		axi_wr(ADDR_PROFILE, 32'h0, RESP_OKAY);
		tel(REQ_READ, 11'h003, 16'h0000, 16'h0000, 16'h0703);
		chk(32'({ctl_now, rsp_key_word}), 32'({exp_ctl(16'h04FC), RSP_WORD, 12'h003}));
		axi_wr(ADDR_PROFILE, 32'(PROFILE_NATIVE), RESP_OKAY);
		$display("test ignore done");
		din_pins[1:0] <= 2'b10;
		for (int m = 0; m < 4; m++) begin
			axi_wr(ADDR_GATE, {24'h000000, 6'h15, 2'(m)}, RESP_OKAY);
			tel(REQ_NONE, 11'h000, 16'h0000, 16'h0000, 16'h047D);
			chk(32'(preset_sel), 32'(gexp[m]));
		end
		axi_rd(ADDR_STATE, 32'h0000_0086, RESP_OKAY);
		din_pins <= 8'h20;
		tel(REQ_NONE, 11'h000, 16'h0000, 16'h0000, 16'h041C);
		@(posedge aclk);
		chk(32'({freq_up, freq_down, run_enable}), 32'h5);
		$display("test gating done");
		wrap_up();
	end
endmodule : dcwd_decoder_tb_top
